/* File: hdl/cbtrim_pkg.sv */
// Purpose: Shared constants for the converter B trim and step-0 slice
// Assumes: 32-bit AHB-Lite register access, one word per register
// Notes:   Printed offsets are register indices; byte address is 4x index
package cbtrim_pkg;
    localparam logic [7:0] IDX_CRC_SPARE = 8'hcd;
    localparam logic [7:0] IDX_OFFSET_TRIM = 8'hce;
    localparam logic [7:0] IDX_GAIN_TRIM = 8'hcf;
    localparam logic [7:0] IDX_STEP_ZERO = 8'hd0;
    localparam logic [9:0] ADDR_CRC_SPARE = {IDX_CRC_SPARE, 2'b00};
    localparam logic [9:0] ADDR_OFFSET_TRIM = {IDX_OFFSET_TRIM, 2'b00};
    localparam logic [9:0] ADDR_GAIN_TRIM = {IDX_GAIN_TRIM, 2'b00};
    localparam logic [9:0] ADDR_STEP_ZERO = {IDX_STEP_ZERO, 2'b00};

    localparam logic [15:0] RST_CRC_SPARE = 16'h0000;
    localparam logic [15:0] RST_OFFSET_TRIM = 16'h0000;
    localparam logic [15:0] RST_GAIN_TRIM = 16'h0000;
    localparam logic [15:0] RST_STEP_ZERO = 16'h0000;

    // Writable-bit masks; all other bits are reserved and read zero
    localparam logic [15:0] MASK_CRC_SPARE = 16'h00ff;
    localparam logic [15:0] MASK_STEP_ZERO = 16'he01f;

    // Step-0 field positions
    localparam int STEP_EN_BIT = 15;
    localparam int STEP_GAIN_HI = 14;
    localparam int STEP_GAIN_LO = 13;
    localparam int STEP_NEG_BIT = 4;
    localparam int STEP_POS_HI = 3;
    localparam int STEP_POS_LO = 0;

    // Gain code decode
    localparam logic [1:0] GAIN_CODE_X1 = 2'h0;
    localparam logic [1:0] GAIN_CODE_X2 = 2'h1;
    localparam logic [1:0] GAIN_SET_X1 = 2'h0;
    localparam logic [1:0] GAIN_SET_X2 = 2'h1;
    localparam logic [1:0] GAIN_SET_X4 = 2'h2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage

/* File: hdl/cbtrim_corrector.sv */
// Purpose: Applies converter B gain and offset trim to a raw result
// Assumes: Result and trims are 16-bit two's complement
// Notes:   One cycle latency; output saturates to 16 bits
`timescale 1ns/10ps
`default_nettype none
module cbtrim_corrector (
    input wire logic i_clk_sys, // System clock
    input wire logic i_reset, // Synchronous reset, active high
    input wire logic i_valid, // Raw result valid
    input wire logic [15:0] i_raw, // Raw conversion result
    input wire logic [15:0] i_offset, // Offset trim code
    input wire logic [15:0] i_gain, // Gain trim code
    input wire logic i_gain_is_one, // Selected gain is 1
    output logic o_valid, // Corrected result valid
    output logic [15:0] o_result // Corrected result
);
    logic signed [17:0] factor;
    logic signed [35:0] product;
    logic signed [35:0] offset_term;
    logic signed [35:0] sum;
    logic signed [19:0] scaled;
    logic [15:0] nxt_result;

    // Factor is 2^16 + code: 0.5 at 8000h up to 1.499985 at 7fffh
    assign factor = 18'sh10000 + 18'(signed'(i_gain));
    assign product = 36'(signed'(i_raw) * factor);
    // Offset step is one result LSB at gain 1, half an LSB otherwise
    assign offset_term = i_gain_is_one ?
        36'(signed'(i_offset)) <<< 16 :
        36'(signed'(i_offset)) <<< 15;
    assign sum = product + offset_term;
    assign scaled = 20'(sum >>> 16);

    always_comb begin
        if (scaled > 20'sh07fff) begin
            nxt_result = 16'h7fff;
        end else if (scaled < -20'sh08000) begin
            nxt_result = 16'h8000;
        end else begin
            nxt_result = scaled[15:0];
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_valid <= 1'b0;
            o_result <= 16'h0000;
        end else begin
            o_valid <= i_valid;
            if (i_valid) begin
                o_result <= nxt_result;
            end
        end
    end
endmodule
`default_nettype wire

/* File: hdl/cbtrim_regs.sv */
// Purpose: Converter B trim registers, spare byte and sequencer step 0
// Assumes: AHB-Lite slave, single word transfers, zero wait states
// Notes:   Step-0 decode outputs steer the analog multiplexer
//
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module cbtrim_regs (
    input wire logic i_clk_sys, // System clock, 250 MHz
    input wire logic i_reset, // Synchronous reset, active high
    input wire logic i_hsel, // AHB slave select
    input wire logic [31:0] i_haddr, // AHB address
    input wire logic [1:0] i_htrans, // AHB transfer type
    input wire logic i_hwrite, // AHB write
    input wire logic [2:0] i_hsize, // AHB size
    input wire logic i_hready, // AHB bus ready
    input wire logic [31:0] i_hwdata, // AHB write data
    output logic [31:0] o_hrdata, // AHB read data
    output logic o_hreadyout, // AHB slave ready
    output logic o_hresp, // AHB response, always OKAY
    input wire logic i_step_zero_req, // Sequencer reaches step 0
    output logic o_step_zero_start, // Step 0 conversion launched
    output logic o_step_zero_skip, // Step 0 skipped, disabled
    output logic [1:0] o_conv_b_gain_setting, // 0:x1 1:x2 2:x4
    output logic [2:0] o_pos_external_sel, // External positive input
    output logic o_pos_is_internal, // Positive input is a monitor
    output logic [7:0] o_pos_internal_sel, // One-hot internal monitor
    output logic o_neg_input_seven, // Negative input is input seven
    output logic o_neg_auto, // Negative input chosen automatically
    input wire logic i_conv_valid, // Raw converter B result valid
    input wire logic [15:0] i_conv_raw, // Raw converter B result
    input wire logic i_conv_step_zero, // Result belongs to step 0
    output logic o_result_valid, // Corrected result valid
    output logic [15:0] o_result // Corrected result
);
    logic [15:0] crc_spare_byte_ff;
    logic [15:0] conv_b_offset_trim_ff;
    logic [15:0] conv_b_gain_trim_ff;
    logic [15:0] conv_b_step_zero_config_ff;
    logic wr_pend_ff;
    logic [9:0] wr_addr_ff;
    logic addr_phase;
    logic [9:0] addr_lo;
    logic addr_hit;
    logic [15:0] nxt_spare;
    logic [15:0] nxt_offset;
    logic [15:0] nxt_gain;
    logic [15:0] nxt_step;
    logic [15:0] nxt_rdata;
    logic step_zero_enable;
    logic [1:0] step_zero_gain_code;
    logic step_zero_negative_select;
    logic [3:0] step_zero_positive_select;
    logic [1:0] nxt_gain_setting;
    logic conv_gain_is_one;
    logic [1:0] active_gain_ff;
    logic step_launch;
    logic pos_is_monitor;
    logic corr_valid;
    logic [15:0] corr_result;

    assign addr_phase = i_hsel & i_hready & (i_htrans == cbtrim_pkg::HTRANS_NONSEQ);
    assign addr_lo = i_haddr[9:0];
    assign addr_hit = (i_haddr[31:10] == 22'h000000);

    // Only word writes raise the pending flag; the address is sampled every cycle, data arrives one cycle later
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            wr_pend_ff <= 1'b0;
        end else begin
            // Narrow writes are dropped rather than merged into a word
            wr_pend_ff <= addr_phase & i_hwrite & addr_hit &
                (i_hsize == cbtrim_pkg::HSIZE_WORD);
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            wr_addr_ff <= 10'h000;
        end else begin
            wr_addr_ff <= addr_lo;
        end
    end

    // Next register values; reserved bits are masked so they stay zero
    always_comb begin
        nxt_spare = crc_spare_byte_ff;
        nxt_offset = conv_b_offset_trim_ff;
        nxt_gain = conv_b_gain_trim_ff;
        nxt_step = conv_b_step_zero_config_ff;
        if (wr_pend_ff) begin
            unique case (wr_addr_ff)
                cbtrim_pkg::ADDR_CRC_SPARE: begin
                    nxt_spare = i_hwdata[15:0] & cbtrim_pkg::MASK_CRC_SPARE;
                end
                cbtrim_pkg::ADDR_OFFSET_TRIM: begin
                    nxt_offset = i_hwdata[15:0];
                end
                cbtrim_pkg::ADDR_GAIN_TRIM: begin
                    nxt_gain = i_hwdata[15:0];
                end
                cbtrim_pkg::ADDR_STEP_ZERO: begin
                    nxt_step = i_hwdata[15:0] & cbtrim_pkg::MASK_STEP_ZERO;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            crc_spare_byte_ff <= cbtrim_pkg::RST_CRC_SPARE;
        end else begin
            crc_spare_byte_ff <= nxt_spare;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            conv_b_offset_trim_ff <= cbtrim_pkg::RST_OFFSET_TRIM;
        end else begin
            conv_b_offset_trim_ff <= nxt_offset;
        end
    end

    // Trims reach the corrector straight from the registers, so a new
    // value applies to the very next raw result
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            conv_b_gain_trim_ff <= cbtrim_pkg::RST_GAIN_TRIM;
        end else begin
            conv_b_gain_trim_ff <= nxt_gain;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            conv_b_step_zero_config_ff <= cbtrim_pkg::RST_STEP_ZERO;
        end else begin
            conv_b_step_zero_config_ff <= nxt_step;
        end
    end

    // Read mux uses next values so a write just ahead is seen at once
    always_comb begin
        nxt_rdata = 16'h0000;
        unique case (addr_lo)
            cbtrim_pkg::ADDR_CRC_SPARE: nxt_rdata = nxt_spare;
            cbtrim_pkg::ADDR_OFFSET_TRIM: nxt_rdata = nxt_offset;
            cbtrim_pkg::ADDR_GAIN_TRIM: nxt_rdata = nxt_gain;
            cbtrim_pkg::ADDR_STEP_ZERO: nxt_rdata = nxt_step;
            default: nxt_rdata = 16'h0000;
        endcase
    end

    // Zero wait states: ready never drops and every answer is OKAY
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end
    end

    // Read data stands until the next read; unmapped reads give zero
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_hrdata <= 32'h00000000;
        end else if (addr_phase & ~i_hwrite) begin
            o_hrdata <= addr_hit ? {16'h0000, nxt_rdata} : 32'h00000000;
        end
    end

    // Field slices of the step-0 word; reserved bits are never looked at
    assign step_zero_enable =
        conv_b_step_zero_config_ff[cbtrim_pkg::STEP_EN_BIT];
    assign step_zero_gain_code = conv_b_step_zero_config_ff[
        cbtrim_pkg::STEP_GAIN_HI:cbtrim_pkg::STEP_GAIN_LO];
    assign step_zero_negative_select =
        conv_b_step_zero_config_ff[cbtrim_pkg::STEP_NEG_BIT];
    assign step_zero_positive_select = conv_b_step_zero_config_ff[
        cbtrim_pkg::STEP_POS_HI:cbtrim_pkg::STEP_POS_LO];

    always_comb begin
        unique case (step_zero_gain_code)
            cbtrim_pkg::GAIN_CODE_X1: nxt_gain_setting = cbtrim_pkg::GAIN_SET_X1;
            cbtrim_pkg::GAIN_CODE_X2: nxt_gain_setting = cbtrim_pkg::GAIN_SET_X2;
            default: nxt_gain_setting = cbtrim_pkg::GAIN_SET_X4;
        endcase
    end

    // Mux settings only change when step 0 is actually launched, so a
    // disabled step never disturbs the front end
    assign step_launch = i_step_zero_req & step_zero_enable;
    assign pos_is_monitor = step_zero_positive_select[3];

    // Start and skip answer each request with a one-cycle pulse
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_step_zero_start <= 1'b0;
            o_step_zero_skip <= 1'b0;
        end else begin
            o_step_zero_start <= step_launch;
            o_step_zero_skip <= i_step_zero_req & ~step_zero_enable;
        end
    end

    // The latched gain also scales the offset of step-0 results
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_conv_b_gain_setting <= cbtrim_pkg::GAIN_SET_X1;
            active_gain_ff <= cbtrim_pkg::GAIN_SET_X1;
        end else if (step_launch) begin
            o_conv_b_gain_setting <= nxt_gain_setting;
            active_gain_ff <= nxt_gain_setting;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_pos_external_sel <= 3'h0;
            o_pos_is_internal <= 1'b0;
        end else if (step_launch) begin
            o_pos_external_sel <= step_zero_positive_select[2:0];
            o_pos_is_internal <= pos_is_monitor;
        end
    end

    // Monitors have their own return path, so the negative bit is ignored
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_neg_input_seven <= 1'b0;
            o_neg_auto <= 1'b0;
        end else if (step_launch) begin
            o_neg_auto <= pos_is_monitor;
            o_neg_input_seven <= ~pos_is_monitor &
                step_zero_negative_select;
        end
    end

    // Order: temp, short, test DAC, analog/4, io/4, digital/2, powers/103
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_mon
            always_ff @(posedge i_clk_sys) begin
                if (i_reset) begin
                    o_pos_internal_sel[gi] <= 1'b0;
                end else if (step_launch) begin
                    o_pos_internal_sel[gi] <= step_zero_positive_select[3] &
                        (step_zero_positive_select[2:0] == 3'(gi));
                end
            end
        end
    endgenerate

    // Results from other steps also pass through the trims; this
    // slice only knows step 0, so those are treated at gain 1
    assign conv_gain_is_one = ~i_conv_step_zero |
        (active_gain_ff == cbtrim_pkg::GAIN_SET_X1);

    cbtrim_corrector u_corr (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_valid(i_conv_valid),
        .i_raw(i_conv_raw),
        .i_offset(conv_b_offset_trim_ff),
        .i_gain(conv_b_gain_trim_ff),
        .i_gain_is_one(conv_gain_is_one),
        .o_valid(corr_valid),
        .o_result(corr_result)
    );

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_result_valid <= 1'b0;
        end else begin
            o_result_valid <= corr_valid;
        end
    end

    // The result holds between valid pulses so a slow reader still sees it
    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            o_result <= 16'h0000;
        end else if (corr_valid) begin
            o_result <= corr_result;
        end
    end
endmodule
`default_nettype wire

/* File: verif/cbtrim_regs_properties.sv */
// Purpose: Port-level checks for the converter B trim and step-0 slice
// Assumes: One clock domain, synchronous active-high reset
// Notes: Attached to cbtrim_regs by the bind at the foot of this file
`timescale 1ns/10ps
`default_nettype none
module cbtrim_regs_properties (
    input wire logic i_clk_sys, // System clock
    input wire logic i_reset, // Synchronous reset
    input wire logic o_hreadyout, // Slave ready
    input wire logic o_hresp, // Slave response
    input wire logic i_step_zero_req, // Step 0 request
    input wire logic o_step_zero_start, // Step 0 launched
    input wire logic o_step_zero_skip, // Step 0 skipped
    input wire logic [1:0] o_conv_b_gain_setting, // Gain setting
    input wire logic [2:0] o_pos_external_sel, // External select
    input wire logic o_pos_is_internal, // Internal monitor chosen
    input wire logic [7:0] o_pos_internal_sel, // One-hot monitor
    input wire logic o_neg_input_seven, // Negative is input seven
    input wire logic o_neg_auto, // Automatic negative input
    input wire logic i_conv_valid, // Raw result valid
    input wire logic o_result_valid // Corrected result valid
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    sequence s_req; i_step_zero_req; endsequence
    sequence s_answer; o_step_zero_start ^ o_step_zero_skip; endsequence
    property p_answer; s_req |=> s_answer; endproperty
    property p_quiet;
        !i_step_zero_req |=> !(o_step_zero_start || o_step_zero_skip);
    endproperty
    // A skipped step must leave the gain setting and positive selects exactly as they were
    property p_skip_hold;
        o_step_zero_skip |-> $stable(o_conv_b_gain_setting)
            && $stable(o_pos_external_sel) && $stable(o_pos_internal_sel);
    endproperty
    property p_mux_cause;
        !$stable(o_pos_external_sel) |-> o_step_zero_start;
    endproperty
    property p_gain; o_conv_b_gain_setting != 2'h3; endproperty
    property p_auto; o_neg_auto == o_pos_is_internal; endproperty
    property p_neg; o_neg_auto |-> !o_neg_input_seven; endproperty
    property p_onehot;
        o_pos_internal_sel ==
            (o_pos_is_internal ? 8'h01 << o_pos_external_sel : 8'h00);
    endproperty
    property p_result; i_conv_valid |-> ##2 o_result_valid; endproperty
    property p_result_cause;
        o_result_valid |-> $past(i_conv_valid, 2);
    endproperty
    property p_bus; o_hreadyout && !o_hresp; endproperty
    a_answer: assert property (p_answer)
        else $error("step request without one answer");
    a_quiet: assert property (p_quiet)
        else $error("step answer without request");
    a_skip_hold: assert property (p_skip_hold)
        else $error("skipped step changed the multiplexer");
    a_mux_cause: assert property (p_mux_cause)
        else $error("positive select changed without start");
    a_gain: assert property (p_gain)
        else $error("gain setting out of range");
    a_auto: assert property (p_auto)
        else $error("automatic negative disagrees with internal");
    a_neg: assert property (p_neg)
        else $error("negative bit not ignored for internal code");
    a_onehot: assert property (p_onehot)
        else $error("internal monitor select wrong");
    a_result: assert property (p_result)
        else $error("corrected result late");
    a_result_cause: assert property (p_result_cause)
        else $error("corrected result without raw result");
    a_bus: assert property (p_bus)
        else $error("bus not ready or not okay");
endmodule
bind cbtrim_regs cbtrim_regs_properties u_chk (.i_clk_sys, .i_reset,
    .o_hreadyout, .o_hresp, .i_step_zero_req, .o_step_zero_start,
    .o_step_zero_skip, .o_conv_b_gain_setting, .o_pos_external_sel,
    .o_pos_is_internal, .o_pos_internal_sel, .o_neg_input_seven,
    .o_neg_auto, .i_conv_valid, .o_result_valid);
`default_nettype wire

/* File: verif/cbtrim_host.sv */
// Purpose: Host model issuing single word transfers on AHB-Lite
// Assumes: The slave may stretch either phase with hready
// Notes: Released address and data show the inverse of the last value
`timescale 1ns/10ps
`default_nettype none
module cbtrim_host (
    input wire logic i_clk_sys, // System clock
    input wire logic i_hready, // Bus ready
    output logic o_hsel, // Slave select
    output logic [31:0] o_haddr, // Address
    output logic [1:0] o_htrans, // Transfer type
    output logic o_hwrite, // Write
    output logic [2:0] o_hsize, // Size
    output logic [31:0] o_hwdata, // Write data
    output logic o_rd_phase // Read data phase under way
);
    initial begin
        o_hsel = 1'b1;
        o_haddr = 32'h0;
        o_htrans = 2'h0;
        o_hwrite = 1'b0;
        o_hsize = cbtrim_pkg::HSIZE_WORD;
        o_hwdata = 32'h0;
        o_rd_phase = 1'b0;
    end
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [31:0] d);
        @(posedge i_clk_sys);
        o_htrans <= cbtrim_pkg::HTRANS_NONSEQ;
        o_haddr <= a;
        o_hwrite <= w;
        do @(posedge i_clk_sys); while (i_hready !== 1'b1);
        o_htrans <= 2'h0;
        o_haddr <= ~a;
        o_hwdata <= w ? d : ~o_hwdata;
        o_rd_phase <= !w;
        do @(posedge i_clk_sys); while (i_hready !== 1'b1);
        o_rd_phase <= 1'b0;
        o_hwdata <= ~o_hwdata;
    endtask
endmodule
`default_nettype wire

/* File: verif/tb.sv */
// Purpose: Self-checking bench for the converter B trim and step-0 slice
// Assumes: Zero-wait slave, result two cycles after raw result
// Notes: Expectations queued by drivers, compared by one watcher
`timescale 1ns/10ps
`default_nettype none
module tb;
    logic i_clk_sys = 1'b0, i_reset = 1'b1, req = 1'b0, cv = 1'b0, sz = 1'b0;
    logic hsel, hwrite, rd_phase, hready, hresp, rv, start, skip;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, gs, lat_gs = 2'h0;
    logic [2:0] hsize, ext;
    logic [15:0] raw = 16'h0, res, otrim = 16'h0, gtrim = 16'h0, mux;
    logic [7:0] isel;
    logic pint, neg7, nauto;
    logic [17:0] stp;
    assign stp = {start, skip, gs, ext, pint, isel, neg7, nauto};
    logic [31:0] rq[$], cq[$], sq[$];
    int n_errors = 0, checks = 0, seed = 32'h949937c8;
    always #2 i_clk_sys = ~i_clk_sys;
    cbtrim_host host (.i_clk_sys(i_clk_sys), .i_hready(hready),
        .o_hsel(hsel), .o_haddr(haddr), .o_htrans(htrans),
        .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata),
        .o_rd_phase(rd_phase));
    cbtrim_regs uut (.i_clk_sys(i_clk_sys), .i_reset(i_reset),
        .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hready(hready),
        .i_hwdata(hwdata), .o_hrdata(hrdata), .o_hreadyout(hready),
        .o_hresp(hresp), .i_step_zero_req(req), .o_step_zero_start(start),
        .o_step_zero_skip(skip), .o_conv_b_gain_setting(gs),
        .o_pos_external_sel(ext), .o_pos_is_internal(pint),
        .o_pos_internal_sel(isel), .o_neg_input_seven(neg7),
        .o_neg_auto(nauto), .i_conv_valid(cv), .i_conv_raw(raw),
        .i_conv_step_zero(sz), .o_result_valid(rv), .o_result(res));
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] s);
        checks++;
        if (s !== e) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", nm, e, s);
        end
    endtask
    always @(posedge i_clk_sys) begin
        if (rd_phase && hready) chk("hrdata", rq.pop_front(), hrdata);
        if (!i_reset && (start || skip) !== 1'b0)
            chk("step", sq.pop_front(), stp);
        if (!i_reset && rv !== 1'b0)
            chk("result", cq.pop_front(), res);
    end
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        rq.push_back(e);
        host.xfer(1'b0, a, 32'h0);
    endtask
    task automatic step(input logic [15:0] c);
        logic [1:0] g;
        g = (c[14:13] == 2'h0) ? 2'h0 : (c[14:13] == 2'h1) ? 2'h1 : 2'h2;
        host.xfer(1'b1, 32'(cbtrim_pkg::ADDR_STEP_ZERO), {16'h0, c});
        // A disabled step keeps the last launched settings
        if (c[15]) mux = {g, c[2:0], c[3], c[3] ? 8'h01 << c[2:0] : 8'h00,
                          !c[3] & c[4], c[3]};
        if (c[15]) lat_gs = g;
        sq.push_back({14'h0, c[15], !c[15], mux});
        @(posedge i_clk_sys);
        req <= 1'b1;
        @(posedge i_clk_sys);
        req <= 1'b0;
    endtask
    task automatic conv(input logic z);
        longint v;
        raw <= 16'($random(seed));
        sz <= z;
        cv <= 1'b1;
        #1;
        v = longint'($signed(raw)) * (65536 + longint'($signed(gtrim)))
            + longint'($signed(otrim)) * ((z && lat_gs != 0) ? 32768 : 65536);
        v = v >>> 16;
        if (v > 32767) v = 32767;
        if (v < -32768) v = -32768;
        cq.push_back({16'h0, v[15:0]});
        @(posedge i_clk_sys);
        cv <= 1'b0;
        repeat (3) @(posedge i_clk_sys);
    endtask
    task automatic close_out;
        if (rq.size() + sq.size() + cq.size() != 0) n_errors++;
        $display("checks %0d mismatches %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #80000;
        n_errors++;
        close_out;
    end
    initial begin
        logic [31:0] ra[4], mk[4], w;
        logic [15:0] gt[5];
        ra = '{32'h334, 32'h338, 32'h33c, 32'h340};
        mk = '{32'(cbtrim_pkg::MASK_CRC_SPARE), 32'hffff, 32'hffff,
               32'(cbtrim_pkg::MASK_STEP_ZERO)};
        gt = '{16'h0000, 16'h7fff, 16'h8000, 16'h0001, 16'hffff};
        mux = 16'h0;
        repeat (10) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        for (int i = 0; i < 4; i++) rd(ra[i], 32'h0);
        rd(32'h344, 32'h0);
        $display("test reset_values done");
        for (int i = 0; i < 4; i++) begin
            w = $random(seed);
            host.xfer(1'b1, ra[i], w);
            rd(ra[i], w & mk[i]);
        end
        $display("test access_masks done");
        for (int i = 0; i < 20; i++)
            step({i % 5 != 0, 2'(i), 8'h0, 1'($random(seed)), 4'(i)});
        $display("test step_codes done");
        host.xfer(1'b1, ra[0], 32'h5a);
        for (int i = 0; i < 8; i++) begin
            otrim = 16'($random(seed));
            gtrim = (i < 5) ? gt[i] : 16'($random(seed));
            host.xfer(1'b1, ra[1], {16'h0, otrim});
            host.xfer(1'b1, ra[2], {16'h0, gtrim});
            step({1'b1, 2'(i), 13'h0});
            conv(1'b1);
            conv(1'b0);
        end
        $display("test trim_results done");
        repeat (4) @(posedge i_clk_sys);
        close_out;
    end
endmodule
`default_nettype wire
